// file: rtl/slice_hdr_regs.svh
// Register offsets, field positions and code constants of the slice header generator.
// Assumes a 32-bit APB slave with byte addresses in the low eight address bits.
`ifndef SLICE_HDR_REGS_SVH
`define SLICE_HDR_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFF_CTRL 8'h00
`define OFF_FORMAT 8'h04
`define OFF_SLICE 8'h08
`define OFF_FRAME 8'h0c
`define OFF_STATUS 8'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTRL_START 0
`define CTRL_FIRST 1
`define CTRL_RECT 2
`define CTRL_ASO 3
`define CTRL_CPM 4
`define CTRL_RRU 5
`define CTRL_ISD 6
`define CTRL_DEBLOCK 7
`define CTRL_SLICEMODE 8
`define FMT_INDEX_LSB 0
`define FMT_ACROSS_LSB 8
`define FMT_COUNT_LSB 16
`define SLICE_MBA_LSB 0
`define SLICE_QUANT_LSB 16
`define SLICE_SUB_LSB 21
`define SLICE_SWI_LSB 24
`define STATUS_BUSY 0
`define STATUS_ERR 1
`define STATUS_PREV 2
`define STATUS_POS_LSB 8
`define STATUS_LAST_LSB 16

// ----------------------------------------------------------------------------
// Codes, reset values and lengths
// ----------------------------------------------------------------------------
`define FMT_CUSTOM 3'h7
`define START_CODE 17'h00001
`define START_CODE_LAST 5'h10
`define RST_QUANT 5'h01
`define BYTE_LAST_POS 3'h7
`define MULTI_PB2_WIDTH 4'h9
`define SINGLE_PB2_WIDTH 4'hb

`endif

// file: rtl/slice_hdr_pkg.sv
// Types shared by the slice header generator.
// Assumes slice_hdr_regs.svh is not needed here; only types live in this package.
package slice_hdr_pkg;

  typedef enum logic [11:0] {
    sIdle = 12'h001,
    sStuff = 12'h002,
    sStart = 12'h004,
    sPb1 = 12'h008,
    sSsbi = 12'h010,
    sMba = 12'h020,
    sPb2 = 12'h040,
    slice_quantizer = 12'h080,
    sSwi = 12'h100,
    sPb3 = 12'h200,
    sGfid = 12'h400,
    sData = 12'h800
  } state_t;

  typedef struct packed {
    state_t st;
    logic [4:0] cnt;
    logic [16:0] shift;
    logic bitData;
    logic bitValid;
    logic [2:0] bitPos;
    logic mbReady;
    logic sliceBegin;
    logic startReq;
    logic first;
    logic rect;
    logic arbitrary_order_submode;
    logic multipoint_flag;
    logic reduced_resolution_update;
    logic isd;
    logic deblock;
    logic sliceMode;
    logic [2:0] fmt;
    logic [7:0] across;
    logic [13:0] count;
    logic [13:0] first_macroblock_address;
    logic [4:0] quant;
    logic [1:0] sub;
    logic [6:0] slice_width_field;
    logic [1:0] frame_identifier;
    logic [13:0] lastMba;
    logic havePrev;
    logic err;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] rectWidth;
    logic filterAcross;
  } ctx_t;

endpackage

// file: rtl/slice_hdr_gen.sv
// Slice header generator: builds slice headers and forwards macroblock bits onto a serial stream.
// Assumes an APB master on mclk and a bit consumer with a valid/ready handshake on mclk.
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "slice_hdr_regs.svh"

module slice_hdr_gen
  import slice_hdr_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic bitData,
  output logic bitValid,
  input wire logic bitReady,
  input wire logic mbBit,
  input wire logic mbValid,
  input wire logic mbLast,
  output logic mbReady,
  output logic sliceBegin,
  output logic sliceModeOn,
  output logic [1:0] submode,
  output logic [7:0] rectWidth,
  output logic filterAcross
);

  // --------------------------------------------------------------------------
  // Format tables, reduced update entries at index six and up
  // --------------------------------------------------------------------------
  localparam logic [13:0] MBA_MAX [0:11] = '{14'h002f, 14'h0062, 14'h018b, 14'h062f,
    14'h18bf, 14'h23ff, 14'h000b, 14'h001d, 14'h0062, 14'h018b, 14'h062f, 14'h08ff};
  localparam logic [3:0] MBA_W [0:11] = '{4'h6, 4'h7, 4'h9, 4'hb, 4'hd, 4'he,
    4'h5, 4'h6, 4'h7, 4'h9, 4'hb, 4'hc};
  localparam logic [7:0] SWI_MAX [0:11] = '{8'h07, 8'h0a, 8'h15, 8'h2b, 8'h57, 8'h7f,
    8'h03, 8'h05, 8'h0a, 8'h15, 8'h2b, 8'h3f};
  localparam logic [3:0] SWI_W [0:11] = '{4'h4, 4'h4, 4'h5, 4'h6, 4'h7, 4'h7,
    4'h3, 4'h3, 4'h4, 4'h5, 4'h6, 4'h6};
  localparam logic [3:0] SUB_BITSTREAM_INDICATOR_CODE [0:3] = '{4'h9, 4'ha, 4'hb, 4'hd};

  ctx_t r;
  ctx_t n;

  // --------------------------------------------------------------------------
  // Table decoding
  // --------------------------------------------------------------------------
  // Custom sizes pick the smallest standard entry that holds them.
  function automatic logic [3:0] mbaIdx(ctx_t c);
    logic [3:0] base;
    logic [3:0] idx;
    base = c.reduced_resolution_update ? 4'h6 : 4'h0;
    idx = base + 4'h5;
    if (c.fmt != `FMT_CUSTOM)
    begin
      idx = base + {1'b0, c.fmt};
    end
    else
    begin
      for (int k = 5; k >= 0; k--)
      begin
        if ({1'b0, MBA_MAX[base + 4'(k)]} + 15'h0001 >= {1'b0, c.count})
        begin
          idx = base + 4'(k);
        end
      end
    end
    return idx;
  endfunction

  function automatic logic [3:0] swiIdx(ctx_t c);
    logic [3:0] base;
    logic [3:0] idx;
    base = c.reduced_resolution_update ? 4'h6 : 4'h0;
    idx = base + 4'h5;
    if (c.fmt != `FMT_CUSTOM)
    begin
      idx = base + {1'b0, c.fmt};
    end
    else
    begin
      for (int k = 5; k >= 0; k--)
      begin
        if ({1'b0, SWI_MAX[base + 4'(k)]} + 9'h001 >= {1'b0, c.across})
        begin
          idx = base + 4'(k);
        end
      end
    end
    return idx;
  endfunction

  function automatic logic [13:0] mbaLimit(ctx_t c);
    return (c.fmt == `FMT_CUSTOM) ? c.count - 14'h0001 : MBA_MAX[mbaIdx(c)];
  endfunction

  function automatic logic needPb2(ctx_t c);
    logic [3:0] w;
    w = MBA_W[mbaIdx(c)];
    if (c.first)
    begin
      return c.rect;
    end
    return c.multipoint_flag ? (w > `MULTI_PB2_WIDTH) : (w > `SINGLE_PB2_WIDTH);
  endfunction

  // Field that follows the one just sent; the first slice skips start code, indicator,
  // quantizer and frame identifier.
  function automatic state_t nextSt(state_t s, ctx_t c);
    state_t ns;
    unique case (s)
      sStart: ns = sPb1;
      sPb1: ns = (c.multipoint_flag && !c.first) ? sSsbi : sMba;
      sSsbi: ns = sMba;
      sMba: ns = needPb2(c) ? sPb2 : (c.first ? (c.rect ? sSwi : sPb3) : slice_quantizer);
      sPb2: ns = c.first ? (c.rect ? sSwi : sPb3) : slice_quantizer;
      slice_quantizer: ns = c.rect ? sSwi : sPb3;
      sSwi: ns = sPb3;
      sPb3: ns = c.first ? sData : sGfid;
      default: ns = sData;
    endcase
    return ns;
  endfunction

  // Bit counter and value of a field; bits leave most significant first.
  function automatic logic [21:0] fieldOf(state_t s, ctx_t c);
    logic [21:0] f;
    unique case (s)
      sStart: f = {`START_CODE_LAST, `START_CODE};
      sPb1, sPb2, sPb3: f = {5'h00, 17'h00001};
      sSsbi: f = {5'h03, 13'h0000, SUB_BITSTREAM_INDICATOR_CODE[c.sub]};
      sMba: f = {1'b0, MBA_W[mbaIdx(c)] - 4'h1, 3'h0, c.first_macroblock_address};
      slice_quantizer: f = {5'h04, 12'h000, c.quant};
      sSwi: f = {1'b0, SWI_W[swiIdx(c)] - 4'h1, 10'h000, c.slice_width_field};
      sGfid: f = {5'h01, 15'h0000, c.frame_identifier};
      default: f = 22'h000000;
    endcase
    return f;
  endfunction

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  logic slotFree;
  logic emit;
  logic startBad;
  logic errSet;
  logic wrDone;
  logic mapped;
  logic [31:0] rdVal;
  state_t ns;
  logic [21:0] fld;

  assign slotFree = !r.bitValid || bitReady;
  assign emit = slotFree && !(r.st inside {sIdle, sData});
  // Out-of-range address; outside the first slice also zero quantizer or address not above the last one without arbitrary order.
  assign startBad = (r.first_macroblock_address > mbaLimit(r))
    || (!r.first && r.quant == 5'h00)
    || (!r.first && !r.arbitrary_order_submode && r.havePrev && r.first_macroblock_address <= r.lastMba);

  always_comb
  begin
    n = r;
    ns = sIdle;
    fld = 22'h000000;
    errSet = 1'b0;
    n.sliceBegin = 1'b0;
    mapped = paddr inside {`OFF_CTRL, `OFF_FORMAT, `OFF_SLICE, `OFF_FRAME, `OFF_STATUS};
    rdVal = 32'h00000000;
    unique case (paddr)
      `OFF_CTRL: rdVal = {23'h000000, r.sliceMode, r.deblock, r.isd, r.reduced_resolution_update, r.multipoint_flag, r.arbitrary_order_submode,
        r.rect, r.first, 1'b0};
      `OFF_FORMAT: rdVal = {2'h0, r.count, r.across, 5'h00, r.fmt};
      `OFF_SLICE: rdVal = {1'b0, r.slice_width_field, 1'b0, r.sub, r.quant, 2'h0, r.first_macroblock_address};
      `OFF_FRAME: rdVal = {30'h00000000, r.frame_identifier};
      `OFF_STATUS: rdVal = {2'h0, r.lastMba, 5'h00, r.bitPos, 5'h00, r.havePrev, r.err,
        (r.st != sIdle) || r.startReq};
      default: rdVal = 32'h00000000;
    endcase
    // One wait state: data and ready are registered in the first access cycle.
    if (psel && penable && !r.pready)
    begin
      n.pready = 1'b1;
      n.prdata = pwrite ? 32'h00000000 : rdVal;
      n.pslverr = !mapped;
    end
    else
    begin
      n.pready = 1'b0;
      n.pslverr = 1'b0;
    end
    if (r.bitValid && bitReady)
    begin
      n.bitValid = 1'b0;
    end
    // Header serialiser.
    if (r.st == sIdle && r.startReq)
    begin
      n.startReq = 1'b0;
      if (startBad)
      begin
        errSet = 1'b1;
      end
      else
      begin
        n.sliceBegin = 1'b1;
        n.lastMba = r.first_macroblock_address;
        n.havePrev = 1'b1;
        ns = r.first ? sPb1 : ((r.bitPos == 3'h0) ? sStart : sStuff);
        n.st = ns;
        fld = fieldOf(ns, r);
        {n.cnt, n.shift} = fld;
      end
    end
    else if (emit)
    begin
      n.bitData = (r.st == sStuff) ? 1'b0 : r.shift[r.cnt];
      n.bitValid = 1'b1;
      n.bitPos = r.bitPos + 3'h1;
      if (r.st == sStuff)
      begin
        if (r.bitPos == `BYTE_LAST_POS)
        begin
          n.st = sStart;
          {n.cnt, n.shift} = fieldOf(sStart, r);
        end
      end
      else if (r.cnt != 5'h00)
      begin
        n.cnt = r.cnt - 5'h01;
      end
      else
      begin
        ns = nextSt(r.st, r);
        n.st = ns;
        fld = fieldOf(ns, r);
        {n.cnt, n.shift} = fld;
      end
    end
    else if (r.st == sData && r.mbReady && mbValid)
    begin
      n.bitData = mbBit;
      n.bitValid = 1'b1;
      n.bitPos = r.bitPos + 3'h1;
      if (mbLast)
      begin
        n.st = sIdle;
      end
    end
    // Macroblock bits are taken only into an empty output slot, which caps them at one
    // bit in two cycles but keeps the ready output a plain flip-flop.
    n.mbReady = (n.st == sData) && !n.bitValid;
    // Settings are frozen while a slice is in flight; such writes are dropped.
    wrDone = psel && penable && r.pready && pwrite && !r.pslverr;
    if (wrDone)
    begin
      if (paddr == `OFF_STATUS && pwdata[`STATUS_ERR])
      begin
        n.err = 1'b0;
      end
      if (r.st == sIdle && !r.startReq)
      begin
        unique case (paddr)
          `OFF_CTRL:
          begin
            n.startReq = pwdata[`CTRL_START];
            n.first = pwdata[`CTRL_FIRST];
            n.rect = pwdata[`CTRL_RECT];
            n.arbitrary_order_submode = pwdata[`CTRL_ASO];
            n.multipoint_flag = pwdata[`CTRL_CPM];
            n.reduced_resolution_update = pwdata[`CTRL_RRU];
            n.isd = pwdata[`CTRL_ISD];
            n.deblock = pwdata[`CTRL_DEBLOCK];
            n.sliceMode = pwdata[`CTRL_SLICEMODE];
          end
          `OFF_FORMAT:
          begin
            n.fmt = pwdata[`FMT_INDEX_LSB +: 3];
            n.across = pwdata[`FMT_ACROSS_LSB +: 8];
            n.count = pwdata[`FMT_COUNT_LSB +: 14];
          end
          `OFF_SLICE:
          begin
            n.first_macroblock_address = pwdata[`SLICE_MBA_LSB +: 14];
            n.quant = pwdata[`SLICE_QUANT_LSB +: 5];
            n.sub = pwdata[`SLICE_SUB_LSB +: 2];
            n.slice_width_field = pwdata[`SLICE_SWI_LSB +: 7];
          end
          `OFF_FRAME: n.frame_identifier = pwdata[1:0];
          default: n.frame_identifier = r.frame_identifier;
        endcase
      end
    end
    n.rectWidth = n.rect ? {1'b0, n.slice_width_field} + 8'h01 : 8'h00;
    n.filterAcross = n.deblock && !n.isd;
    n.err = n.err || errSet;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      r <= '0;
      r.st <= sIdle;
      r.quant <= `RST_QUANT;
    end
    else
    begin
      r <= n;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign bitData = r.bitData;
  assign bitValid = r.bitValid;
  assign mbReady = r.mbReady;
  assign sliceBegin = r.sliceBegin;
  assign sliceModeOn = r.sliceMode;
  assign submode = {r.arbitrary_order_submode, r.rect};
  assign rectWidth = r.rectWidth;
  assign filterAcross = r.filterAcross;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sequence accept_s;
    r.st == sIdle && r.startReq && !startBad;
  endsequence

  sequence pulse_s;
    sliceBegin ##1 !sliceBegin;
  endsequence

  stuff_zero_a: assert property (emit && r.st == sStuff |=> !bitData && bitValid)
    else $error("stuffing bit was not zero");
  code_aligned_a: assert property (emit && r.st == sStart
    && r.cnt == `START_CODE_LAST |-> r.bitPos == 3'h0)
    else $error("start code not byte aligned");
  code_pattern_a: assert property (emit && r.st == sStart
    |=> bitData == ($past(r.cnt) == 5'h00))
    else $error("start code bit wrong");
  prevent_one_a: assert property (emit && (r.st inside {sPb1, sPb2, sPb3}) |=> bitData)
    else $error("prevention bit not one");
  order_strict_a: assert property (r.st == sIdle && r.startReq && !r.first && !r.arbitrary_order_submode
    && r.havePrev && r.first_macroblock_address <= r.lastMba |=> r.err && r.st == sIdle)
    else $error("falling slice address was not refused");
  slice_pulse_a: assert property (accept_s |=> pulse_s)
    else $error("slice begin pulse missing");
  first_fields_a: assert property (
    (r.st inside {sStart, sSsbi, slice_quantizer, sGfid}) |-> !r.first)
    else $error("field sent in first slice");
  sub_bitstream_indicator_code_a: assert property (r.st == sSsbi
    |-> r.shift[3:0] inside {4'h9, 4'ha, 4'hb, 4'hd})
    else $error("bad sub-bitstream code");
  quant_range_a: assert property (r.st == slice_quantizer |-> r.quant != 5'h00)
    else $error("zero quantizer sent");

endmodule // slice_hdr_gen

// file: verification/bit_sink_model.sv
// Far-end model: a slice bitstream reader that logs every bit taken and counts start codes.
// Assumes the generator's bitData/bitValid/bitReady stream on mclk.
`timescale 1ns/10ps

module bit_sink_model
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic bitData,
  input wire logic bitValid,
  output logic bitReady
);
  logic [1:0] stall_r;
  int zeroRun;
  int syncs;
  logic bitLog[$];

  // ---------------------------------------------------------------------------
  // Reader
  // ---------------------------------------------------------------------------
  // Ready drops one cycle in three, so the generator must hold each bit.
  assign bitReady = (stall_r != 2'h2);

  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      stall_r <= 2'h0;
      zeroRun = 0;
      syncs = 0;
    end
    else
    begin
      stall_r <= (stall_r == 2'h2) ? 2'h0 : stall_r + 2'h1;
      if (bitValid && bitReady)
      begin
        // Zeros beyond sixteen are stuffing; a code counts only if its last sixteen zeros start on a byte boundary.
        if (bitData && zeroRun >= 16 && ((bitLog.size() - 16) % 8) == 0)
          syncs++;
        zeroRun = bitData ? 0 : zeroRun + 1;
        bitLog.push_back(bitData);
      end
    end
  end
endmodule // bit_sink_model

// file: verification/video_slice_header_codec_test.sv
// Self-checking bench for the slice header generator.
// Assumes slice_hdr_gen, bit_sink_model and the register header are compiled alongside.
`timescale 1ns/10ps
`include "slice_hdr_regs.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
  $display("mismatch at %0t: value differs on line %0d", $time, `__LINE__); end end

module video_slice_header_codec_test
  import slice_hdr_pkg::*;
;
  logic mclk, resetn, psel, penable, pwrite, pslverr, pready;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic bitData, bitValid, bitReady, mbBit, mbValid, mbLast, mbReady, rerr;
  logic sliceBegin, sliceModeOn, filterAcross;
  logic [1:0] submode;
  logic [7:0] rectWidth;
  int num_errors, checks_done, cycles, base, s, begins;
  logic expBits[$];

  slice_hdr_gen slice_hdr_gen_i (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bitData(bitData), .bitValid(bitValid), .bitReady(bitReady),
    .mbBit(mbBit), .mbValid(mbValid), .mbLast(mbLast), .mbReady(mbReady),
    .sliceBegin(sliceBegin), .sliceModeOn(sliceModeOn), .submode(submode),
    .rectWidth(rectWidth), .filterAcross(filterAcross));

  bit_sink_model bit_sink_model_i (.mclk(mclk), .resetn(resetn), .bitData(bitData),
    .bitValid(bitValid), .bitReady(bitReady));

  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      $display("mismatch at %0t: run took too long", $time);
      test_done();
    end
  end

  // Every slice-begin pulse is counted, so each scenario can tell accepted starts from refused.
  always @(posedge mclk)
    if (sliceBegin === 1'b1)
      begins++;

  // Pready is sampled at the rising edge itself, before that edge's register updates land.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pushf(input logic [15:0] v, input int w);
    for (int i = w - 1; i >= 0; i--)
      expBits.push_back(v[i]);
  endtask

  task automatic begin_exp();
    expBits.delete();
    base = bit_sink_model_i.bitLog.size();
  endtask

  task automatic stuff();
    pushf(16'h0000, (8 - (base % 8)) % 8);
  endtask

  task automatic feed_mb();
    logic [2:0] pat;
    pat = 3'h5;
    for (int i = 2; i >= 0; i--)
    begin
      @(posedge mclk);
      mbBit <= pat[i];
      mbValid <= 1'b1;
      mbLast <= (i == 0);
      do
        @(posedge mclk);
      while (mbReady !== 1'b1);
      mbValid <= 1'b0;
    end
  endtask

  // Starts a slice, sends three macroblock bits and compares the whole stream segment.
  task automatic run_slice(input logic [31:0] ctrl);
    int b;
    b = begins;
    pushf(16'h0005, 3);
    apb(1'b1, `OFF_CTRL, ctrl);
    feed_mb();
    for (int n = 0; n < 100; n++)
    begin
      apb(1'b0, `OFF_STATUS, 32'h0);
      if (rd[`STATUS_BUSY] === 1'b0)
        break;
    end
    // The last bit may still sit in the output slot when busy clears.
    repeat (4) @(posedge mclk);
    `CHK(rd[`STATUS_BUSY], 1'b0)
    `CHK(begins, b + 1)
    `CHK(bit_sink_model_i.bitLog.size(), base + expBits.size())
    for (int i = 0; i < expBits.size(); i++)
      `CHK(bit_sink_model_i.bitLog[base + i], expBits[i])
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic test_reset_values();
    apb(1'b0, `OFF_SLICE, 32'h0);
    `CHK(rd, 32'h00010000)
    apb(1'b0, `OFF_CTRL, 32'h0);
    `CHK(rd, 32'h00000000)
    apb(1'b0, 8'h14, 32'h0);
    `CHK(rerr, 1'b1)
    `CHK(rd, 32'h00000000)
  endtask

  task automatic test_first_rect();
    apb(1'b1, `OFF_FORMAT, 32'h00000002);
    apb(1'b1, `OFF_SLICE, 32'h03000014);
    apb(1'b1, `OFF_FRAME, 32'h0);
    begin_exp();
    pushf(16'h0001, 1);
    pushf(16'd20, 9);
    pushf(16'h0001, 1);
    pushf(16'h0003, 5);
    pushf(16'h0001, 1);
    run_slice(32'h00000187);
    `CHK(rectWidth, 8'h04)
    `CHK(submode, 2'b01)
    `CHK(sliceModeOn, 1'b1)
    `CHK(filterAcross, 1'b1)
  endtask

  task automatic test_cpm_slice();
    apb(1'b1, `OFF_FORMAT, 32'h00000001);
    apb(1'b1, `OFF_SLICE, 32'h0045001e);
    apb(1'b1, `OFF_FRAME, 32'h00000002);
    begin_exp();
    s = bit_sink_model_i.syncs;
    stuff();
    pushf(16'h0000, 16);
    pushf(16'h0003, 2);
    pushf(16'h000b, 4);
    pushf(16'd30, 7);
    pushf(16'h0005, 5);
    pushf(16'h0001, 1);
    pushf(16'h0002, 2);
    run_slice(32'h00000111);
    `CHK(bit_sink_model_i.syncs, s + 1)
    `CHK(rectWidth, 8'h00)
    `CHK(submode, 2'b00)
  endtask

  task automatic test_order_aso();
    apb(1'b1, `OFF_FORMAT, 32'h00000004);
    apb(1'b1, `OFF_SLICE, 32'h00050005);
    apb(1'b1, `OFF_FRAME, 32'h00000001);
    begin_exp();
    s = begins;
    apb(1'b1, `OFF_CTRL, 32'h00000101);
    apb(1'b0, `OFF_STATUS, 32'h0);
    `CHK(rd[`STATUS_ERR], 1'b1)
    `CHK(bit_sink_model_i.bitLog.size(), base)
    `CHK(begins, s)
    apb(1'b1, `OFF_STATUS, 32'h00000002);
    stuff();
    pushf(16'h0000, 16);
    pushf(16'h0003, 2);
    pushf(16'h0005, 13);
    pushf(16'h0001, 1);
    pushf(16'h0005, 5);
    pushf(16'h0001, 1);
    pushf(16'h0001, 2);
    run_slice(32'h00000109);
  endtask

  // Custom size in reduced update mode: fifty macroblocks give a seven-bit address, top 49.
  task automatic test_custom_rru();
    apb(1'b1, `OFF_FORMAT, 32'h00320007);
    apb(1'b1, `OFF_SLICE, 32'h00000032);
    begin_exp();
    s = begins;
    apb(1'b1, `OFF_CTRL, 32'h000001e3);
    apb(1'b0, `OFF_STATUS, 32'h0);
    `CHK(rd[`STATUS_ERR], 1'b1)
    `CHK(bit_sink_model_i.bitLog.size(), base)
    `CHK(begins, s)
    apb(1'b1, `OFF_STATUS, 32'h00000002);
    apb(1'b1, `OFF_SLICE, 32'h00000031);
    pushf(16'h0001, 1);
    pushf(16'd49, 7);
    pushf(16'h0001, 1);
    run_slice(32'h000001e3);
    `CHK(filterAcross, 1'b0)
  endtask

  initial
  begin
    num_errors = 0;
    checks_done = 0;
    cycles = 0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mbBit = 1'b0;
    mbValid = 1'b0;
    mbLast = 1'b0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    test_reset_values();
    test_first_rect();
    test_cpm_slice();
    test_order_aso();
    test_custom_rru();
    test_done();
  end
endmodule // video_slice_header_codec_test
